// *** hw/adcc_top.sv ***
// Converter control: AHB-Lite registers, compare, sequencing and low-power behaviour
`timescale 1ns/1ps

// Three-stage synchroniser; output moves only when stages two and three agree
module adcc_sync3 (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;

    // First stage is read by the second only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

module adcc_top
    import adcc_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic             wait_mode,
    input  wire logic             stop3_mode,
    input  wire logic             stop12_mode,
    input  wire logic             hw_trigger_input,
    input  wire logic             alternate_clock,
    input  wire logic             async_conv_clock,
    input  wire logic             conv_done,
    input  wire logic [RES_W-1:0] conv_data,
    output logic                  conv_start,
    output logic                  conv_abort,
    output logic                  adck_tick,
    output logic                  async_clk_enable,
    output adcc_analog_cfg_t      analog_cfg,
    output logic                  conv_irq,
    output logic                  wake_req,
    output logic [15:0]           pin_digital_disable
);
    adcc_state_t      state;
    adcc_state_t      next_state;
    adcc_aphase_t     aph;
    adcc_aphase_t     next_aph;
    logic [7:0]       cfg;
    logic             hw_trg_sel;
    logic             cmp_en;
    logic             cmp_gt;
    logic             irq_en;
    logic             cont_sel;
    logic [4:0]       chan;
    logic             flag;
    logic             blocked;
    logic [RES_W-1:0] result;
    logic [1:0]       cv_high;
    logic [7:0]       cv_low;
    logic [7:0]       pin_ctl1;
    logic [7:0]       pin_ctl2;
    logic             rd_wait;
    logic [7:0]       rd_mux;
    logic             stop3_q;
    logic             trg_lvl;
    logic             trg_prev;
    logic             alt_lvl;
    logic             alt_prev;
    logic             ack_lvl;
    logic             ack_prev;
    logic             half;
    logic [2:0]       div_cnt;

    // Bus decode
    wire              accept     = hsel & htrans[TRANS_ACT_BIT] & hready;
    wire              wr_fire    = aph.valid & aph.write & hready;
    wire [7:0]        wdat       = hwdata[BYTE_W-1:0];
    wire              wr_cfg     = wr_fire & (aph.addr == ADDR_CFG);
    wire              wr_sc2     = wr_fire & (aph.addr == ADDR_SC2);
    wire              wr_sc1     = wr_fire & (aph.addr == ADDR_SC1);
    wire              wr_cvh     = wr_fire & (aph.addr == ADDR_CVH);
    wire              wr_cvl     = wr_fire & (aph.addr == ADDR_CVL);
    wire              wr_pctl1   = wr_fire & (aph.addr == ADDR_PCTL1);
    wire              wr_pctl2   = wr_fire & (aph.addr == ADDR_PCTL2);
    wire              rd_resh    = rd_wait & (aph.addr == ADDR_RESH);
    wire              rd_resl    = rd_wait & (aph.addr == ADDR_RESL);

    // Configuration fields
    wire              ten_bit    = cfg[CFG_MODE_HI:CFG_MODE_LO] == MODE_10BIT;
    wire [1:0]        clk_src    = cfg[CFG_CLK_HI:CFG_CLK_LO];
    wire [1:0]        clk_div    = cfg[CFG_DIV_HI:CFG_DIV_LO];
    wire              async_sel  = clk_src == CLK_ASYNC;

    // Low-power handling; wait mode deliberately gates nothing
    wire              frozen     = (stop3_mode & ~async_sel) | stop12_mode;
    wire              lp_abort   = stop3_mode & ~stop3_q & ~async_sel;
    wire              mode_abort = wr_sc2 | wr_cfg | wr_cvh | wr_cvl;
    wire              any_abort  = mode_abort | wr_sc1 | lp_abort | stop12_mode;
    wire              busy       = state == ADCC_CONV;

    // Start sources; trigger edges are ignored while busy
    wire              trg_edge   = trg_lvl & ~trg_prev;
    wire              sw_start   = wr_sc1 & (wdat[SC1_CH_HI:SC1_CH_LO] != CH_OFF) & ~hw_trg_sel & ~frozen;
    wire              hw_start   = trg_edge & hw_trg_sel & ~busy & (chan != CH_OFF) & ~frozen & ~any_abort;

    // Compare arithmetic; 8-bit mode works on the low byte only
    wire [RES_W-1:0]  data_w     = ten_bit ? conv_data : RES_W'(conv_data[BYTE_W-1:0]);
    wire [RES_W-1:0]  cv_w       = ten_bit ? {cv_high, cv_low} : RES_W'(cv_low);
    wire [RES_W-1:0]  diff_full  = data_w + ~cv_w + RES_W'(1);
    wire [RES_W-1:0]  diff       = ten_bit ? diff_full : RES_W'(diff_full[BYTE_W-1:0]);
    wire              at_above   = data_w >= cv_w;
    wire              cond_met   = ~cmp_en | (cmp_gt ? at_above : ~at_above);

    // Completion; an abort in the same cycle discards the result
    wire              done_ok    = conv_done & busy & ~any_abort;
    wire              transfer   = done_ok & cond_met & ~blocked;
    wire              cmp_false  = cmp_en & ~cond_met;
    wire              restart    = done_ok & (cmp_false ? cont_sel : (blocked | cont_sel));

    // Flag and blocking updates; set wins over clear
    wire              flag_clr   = wr_sc1 | rd_resl;
    wire              next_flag  = transfer | (flag & ~flag_clr);
    wire              next_block = (rd_resh & ten_bit) | (blocked & ~rd_resl);

    // Conversion clock: source select and power-of-two divider
    wire              src_tick   = (clk_src == CLK_BUS)      ? 1'b1 :
                                   (clk_src == CLK_BUS_HALF) ? half :
                                   (clk_src == CLK_ALT)      ? (alt_lvl & ~alt_prev) :
                                                               (ack_lvl & ~ack_prev);
    wire [2:0]        div_lim    = 3'((4'h1 << clk_div) - 4'h1);
    wire              div_wrap   = (div_cnt & div_lim) == div_lim;

    assign next_aph  = '{addr: haddr[ADDR_W-1:0], write: hwrite, valid: accept};
    assign hreadyout = ~rd_wait;
    assign hresp     = HRESP_OKAY;

    // Handshakes to the analog core
    assign conv_start       = sw_start | hw_start | restart;
    assign conv_abort       = busy & any_abort;
    assign async_clk_enable = async_sel & busy;

    // Interrupt is a level from flag and enable; wake only in low-power modes
    assign conv_irq = flag & irq_en;
    assign wake_req = conv_irq & (wait_mode | stop3_mode);

    // Analog settings straight from the registers
    assign analog_cfg          = '{channel: chan, long_sample: cfg[CFG_LS_BIT], low_power: cfg[CFG_LP_BIT],
                                   ten_bit: ten_bit};
    assign pin_digital_disable = {pin_ctl2, pin_ctl1};

    // Pin synchronisers
    adcc_sync3 u_sync_trg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (hw_trigger_input),
        .dout    (trg_lvl)
    );

    adcc_sync3 u_sync_alt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (alternate_clock),
        .dout    (alt_lvl)
    );

    adcc_sync3 u_sync_ack (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (async_conv_clock),
        .dout    (ack_lvl)
    );

    // Read mux
    always_comb begin
        rd_mux = REG_RESET;
        if (aph.addr == ADDR_CFG) begin
            rd_mux = cfg;
        end else if (aph.addr == ADDR_SC2) begin
            rd_mux = {busy, hw_trg_sel, cmp_en, cmp_gt, 4'h0};
        end else if (aph.addr == ADDR_SC1) begin
            rd_mux = {flag, irq_en, cont_sel, chan};
        end else if (aph.addr == ADDR_RESH) begin
            rd_mux = ten_bit ? {6'h00, result[RES_W-1:BYTE_W]} : REG_RESET;
        end else if (aph.addr == ADDR_RESL) begin
            rd_mux = result[BYTE_W-1:0];
        end else if (aph.addr == ADDR_CVH) begin
            rd_mux = {6'h00, cv_high};
        end else if (aph.addr == ADDR_CVL) begin
            rd_mux = cv_low;
        end else if (aph.addr == ADDR_PCTL1) begin
            rd_mux = pin_ctl1;
        end else if (aph.addr == ADDR_PCTL2) begin
            rd_mux = pin_ctl2;
        end
    end

    // Sequencer: abort beats completion, a software start beats abort
    always_comb begin
        next_state = state;
        case (state)
            ADCC_IDLE: begin
                if (sw_start | hw_start) begin
                    next_state = ADCC_CONV;
                end
            end
            ADCC_CONV: begin
                if (sw_start) begin
                    next_state = ADCC_CONV;
                end else if (any_abort) begin
                    next_state = ADCC_IDLE;
                end else if (done_ok & ~restart) begin
                    next_state = ADCC_IDLE;
                end
            end
            default: begin
                next_state = ADCC_IDLE;
            end
        endcase
    end

    // Bus phase tracking; reads take one wait state so writes land first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph     <= '0;
            rd_wait <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end else begin
            if (hready) begin
                aph <= next_aph;
            end
            rd_wait <= accept & ~hwrite;
            if (rd_wait) begin
                hrdata <= 32'(rd_mux);
            end
        end
    end

    // Configuration and control registers; stop1/stop2 reload reset values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg        <= REG_RESET;
            hw_trg_sel <= 1'b0;
            cmp_en     <= 1'b0;
            cmp_gt     <= 1'b0;
            irq_en     <= 1'b0;
            cont_sel   <= 1'b0;
            chan       <= CH_RESET;
        end else if (stop12_mode) begin
            cfg        <= REG_RESET;
            hw_trg_sel <= 1'b0;
            cmp_en     <= 1'b0;
            cmp_gt     <= 1'b0;
            irq_en     <= 1'b0;
            cont_sel   <= 1'b0;
            chan       <= CH_RESET;
        end else begin
            if (wr_cfg) begin
                cfg <= wdat;
            end
            if (wr_sc2) begin
                hw_trg_sel <= wdat[SC2_TRG_BIT];
                cmp_en     <= wdat[SC2_CFE_BIT];
                cmp_gt     <= wdat[SC2_CFGT_BIT];
            end
            if (wr_sc1) begin
                irq_en   <= wdat[SC1_IEN_BIT];
                cont_sel <= wdat[SC1_CONT_BIT];
                chan     <= wdat[SC1_CH_HI:SC1_CH_LO];
            end
        end
    end

    // Compare value and pin control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cv_high  <= 2'h0;
            cv_low   <= REG_RESET;
            pin_ctl1 <= REG_RESET;
            pin_ctl2 <= REG_RESET;
        end else if (stop12_mode) begin
            cv_high  <= 2'h0;
            cv_low   <= REG_RESET;
            pin_ctl1 <= REG_RESET;
            pin_ctl2 <= REG_RESET;
        end else begin
            if (wr_cvh) begin
                cv_high <= wdat[RES_W-BYTE_W-1:0];
            end
            if (wr_cvl) begin
                cv_low <= wdat;
            end
            if (wr_pctl1) begin
                pin_ctl1 <= wdat;
            end
            if (wr_pctl2) begin
                pin_ctl2 <= wdat;
            end
        end
    end

    // Result, flag and blocking; results survive aborts and stop3
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result  <= RES_RESET;
            flag    <= 1'b0;
            blocked <= 1'b0;
        end else if (stop12_mode) begin
            result  <= RES_RESET;
            flag    <= 1'b0;
            blocked <= 1'b0;
        end else begin
            if (transfer) begin
                result <= cmp_en ? diff : data_w;
            end
            flag    <= next_flag;
            blocked <= next_block;
        end
    end

    // Sequencer state, mode edge and pin edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= ADCC_IDLE;
            stop3_q  <= 1'b0;
            trg_prev <= 1'b0;
            alt_prev <= 1'b0;
            ack_prev <= 1'b0;
        end else begin
            state    <= next_state;
            stop3_q  <= stop3_mode;
            trg_prev <= trg_lvl;
            alt_prev <= alt_lvl;
            ack_prev <= ack_lvl;
        end
    end

    // Divider restarts in idle so each conversion started from idle sees a full first period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half      <= 1'b0;
            div_cnt   <= 3'h0;
            adck_tick <= 1'b0;
        end else begin
            half      <= ~half;
            adck_tick <= busy & src_tick & div_wrap;
            if (!busy) begin
                div_cnt <= 3'h0;
            end else if (src_tick) begin
                div_cnt <= div_cnt + 3'h1;
            end
        end
    end
endmodule

// *** hw/adcc_pkg.sv ***
// Package: register map, field layout, codes and carrier types of the converter control block
package adcc_pkg;
    // Bus view
    localparam int         ADDR_W        = 8;
    localparam int         BYTE_W        = 8;
    localparam int         RES_W         = 10;
    localparam int         TRANS_ACT_BIT = 1;
    localparam logic       HRESP_OKAY    = 1'b0;
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG      = 8'h00;
    localparam logic [7:0] ADDR_SC2      = 8'h04;
    localparam logic [7:0] ADDR_SC1      = 8'h08;
    localparam logic [7:0] ADDR_RESH     = 8'h0C;
    localparam logic [7:0] ADDR_RESL     = 8'h10;
    localparam logic [7:0] ADDR_CVH      = 8'h14;
    localparam logic [7:0] ADDR_CVL      = 8'h18;
    localparam logic [7:0] ADDR_PCTL1    = 8'h1C;
    localparam logic [7:0] ADDR_PCTL2    = 8'h20;
    // Configuration fields
    localparam int         CFG_LP_BIT    = 7;
    localparam int         CFG_DIV_HI    = 6;
    localparam int         CFG_DIV_LO    = 5;
    localparam int         CFG_LS_BIT    = 4;
    localparam int         CFG_MODE_HI   = 3;
    localparam int         CFG_MODE_LO   = 2;
    localparam int         CFG_CLK_HI    = 1;
    localparam int         CFG_CLK_LO    = 0;
    // Trigger/compare control fields
    localparam int         SC2_TRG_BIT   = 6;
    localparam int         SC2_CFE_BIT   = 5;
    localparam int         SC2_CFGT_BIT  = 4;
    // Channel/complete control fields
    localparam int         SC1_IEN_BIT   = 6;
    localparam int         SC1_CONT_BIT  = 5;
    localparam int         SC1_CH_HI     = 4;
    localparam int         SC1_CH_LO     = 0;
    // Codes
    localparam logic [1:0] DIV_BY_ONE    = 2'h0;
    localparam logic [1:0] MODE_10BIT    = 2'h2;
    localparam logic [1:0] CLK_BUS       = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF  = 2'h1;
    localparam logic [1:0] CLK_ALT       = 2'h2;
    localparam logic [1:0] CLK_ASYNC     = 2'h3;
    localparam logic [4:0] CH_INPUT_ONE  = 5'h01;
    localparam logic [4:0] CH_OFF        = 5'h1F;
    localparam logic [7:0] PIN_ONE_FREE  = 8'h02;
    // Reset values
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [4:0] CH_RESET      = CH_OFF;
    localparam logic [9:0] RES_RESET     = 10'h000;

    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b01,
        ADCC_CONV = 2'b10
    } adcc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              valid;
    } adcc_aphase_t;

    typedef struct packed {
        logic [4:0] channel;
        logic       long_sample;
        logic       low_power;
        logic       ten_bit;
    } adcc_analog_cfg_t;
endpackage

// *** dv/adcc_props.sv ***
// Checker: bus timing, start/abort and low-power assertions on the converter control ports
`timescale 1ns/1ps
module adcc_props_chk
    import adcc_pkg::*;
(
    input wire logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0]      haddr, hwdata,
    input wire logic [1:0]       htrans,
    input wire logic             wait_mode, stop3_mode, stop12_mode, conv_done, conv_start,
    input wire logic             conv_abort, adck_tick, async_clk_enable, conv_irq, wake_req,
    input wire adcc_analog_cfg_t analog_cfg,
    input wire logic [15:0]      pin_digital_disable
);
    logic       busy, dph_wr, dph_rd, trg_sel;
    logic [7:0] dph_addr;
    logic [1:0] clk_code;
    // Decoded data phases
    wire logic  taken   = hsel && htrans[TRANS_ACT_BIT] && hready;
    wire logic  cfg_wr  = dph_wr && dph_addr == ADDR_CFG;
    wire logic  sc2_wr  = dph_wr && dph_addr == ADDR_SC2;
    wire logic  sc1_wr  = dph_wr && dph_addr == ADDR_SC1;
    wire logic  mode_wr = cfg_wr || sc2_wr || (dph_wr && (dph_addr == ADDR_CVH || dph_addr == ADDR_CVL));
    // Shadow of phase, clock code, trigger mode and activity; stop1/2 clears all but the phase like reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {busy, dph_wr, dph_rd, trg_sel, dph_addr, clk_code} <= '0;
        end else begin
            dph_wr   <= taken && hwrite;
            dph_rd   <= taken && !hwrite;
            dph_addr <= taken ? haddr[7:0] : dph_addr;
            clk_code <= stop12_mode ? CLK_BUS : cfg_wr ? hwdata[1:0] : clk_code;
            trg_sel  <= stop12_mode ? 1'b0 : sc2_wr ? hwdata[SC2_TRG_BIT] : trg_sel;
            busy     <= stop12_mode ? 1'b0 : conv_start ? 1'b1 : (conv_done || conv_abort) ? 1'b0 : busy;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_read_wait: assert property (dph_rd |-> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    chk_wake_level: assert property (wake_req == (conv_irq && (wait_mode || stop3_mode)))
        else $error("wake request wrong");
    chk_sw_start: assert property (sc1_wr && hwdata[4:0] != CH_OFF && !trg_sel && !stop3_mode && !stop12_mode
        |-> conv_start) else $error("channel write did not start");
    chk_mode_abort: assert property (mode_wr && busy |-> ##[0:1] conv_abort)
        else $error("mode write did not abort");
    chk_stop3_idle: assert property (stop3_mode && $past(stop3_mode) && clk_code != CLK_ASYNC
        |-> !conv_start && !busy) else $error("converter active in stop3");
    chk_async_run: assert property (busy && clk_code == CLK_ASYNC |-> async_clk_enable)
        else $error("async clock not enabled");
    chk_tick_busy: assert property (adck_tick |-> busy || $past(busy))
        else $error("tick while idle");
    chk_stop12_clear: assert property (stop12_mode |=> analog_cfg.channel == CH_RESET && !conv_irq
        && pin_digital_disable == 16'h0000) else $error("stop1/2 did not clear");
endmodule

// *** dv/adcc_top_tb.sv ***
// Testbench: register access, compare, blocking, abort and low-power scenarios
`timescale 1ns/1ps
module adcc_top_tb
    import adcc_pkg::*;
;
    logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]       htrans = 2'h0;
    logic [9:0]       conv_data = 10'h000, exp_res;
    logic             wait_mode = 1'b0, stop3_mode = 1'b0, stop12_mode = 1'b0, hw_trigger_input = 1'b0;
    logic             async_conv_clock = 1'b0, conv_done = 1'b0, hready, hreadyout, hresp;
    logic             conv_start, conv_abort, adck_tick, async_clk_enable, conv_irq, wake_req;
    logic [15:0]      pin_digital_disable;
    adcc_analog_cfg_t analog_cfg;
    logic [9:0]       cmp_dat [5] = '{10'h180, 10'h100, 10'h0FF, 10'h0FF, 10'h100};
    logic [4:0]       cmp_gt = 5'h07, cmp_hit = 5'h0B;
    int               fail_count = 0, total_checks = 0, start_count = 0, n;
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;
    // Async source toggles each rising edge; starts are counted to see triggers land
    always @(posedge hclk) begin
        async_conv_clock <= ~async_conv_clock;
        start_count <= start_count + int'(conv_start === 1'b1);
    end
    adcc_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .wait_mode(wait_mode), .stop3_mode(stop3_mode), .stop12_mode(stop12_mode),
        .hw_trigger_input(hw_trigger_input), .alternate_clock(1'b0), .async_conv_clock(async_conv_clock),
        .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start), .conv_abort(conv_abort),
        .adck_tick(adck_tick), .async_clk_enable(async_clk_enable), .analog_cfg(analog_cfg),
        .conv_irq(conv_irq), .wake_req(wake_req), .pin_digital_disable(pin_digital_disable)
    );
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Hready settles mid-cycle, so the negedge value is what the next edge samples
    task automatic wait_rdy(output logic [7:0] d);
        logic r;
        do begin
            @(negedge hclk);
            r = hready;
            d = hrdata[7:0];
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy(rd);
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        wait_rdy(rd);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] x;
        bus(a, 1'b0, 8'h00, x);
        check(name, {8'h00, x}, {8'h00, e});
    endtask
    // Core reports one result, then releases the data lines to a changed value
    task automatic finish_conv(input logic [9:0] d);
        conv_data <= d;
        conv_done <= 1'b1;
        @(posedge hclk);
        conv_done <= 1'b0;
        conv_data <= ~d;
        repeat (2) @(posedge hclk);
    endtask
    // Whole map including one unmapped word
    task automatic reset_vals;
        logic [7:0] a [10] = '{ADDR_CFG, ADDR_SC2, ADDR_SC1, ADDR_RESH, ADDR_RESL, ADDR_CVH, ADDR_CVL,
                               ADDR_PCTL1, ADDR_PCTL2, 8'h24};
        for (int i = 0; i < 10; i++) begin
            rd_chk("reset_value", a[i], (a[i] == ADDR_SC1) ? {3'h0, CH_RESET} : REG_RESET);
        end
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_vals();
        wr(ADDR_SC2, 8'hFF);
        rd_chk("sc2_fields", ADDR_SC2, 8'h70);
        wr(ADDR_SC1, 8'hFF);
        rd_chk("sc1_fields", ADDR_SC1, 8'h7F);
        // Bring-up order, single 10-bit conversion on input one
        wr(ADDR_CFG, 8'h98);
        wr(ADDR_SC2, 8'h00);
        wr(ADDR_SC1, 8'h41);
        finish_conv(10'h2A5);
        wr(ADDR_PCTL1, PIN_ONE_FREE);
        wait_mode <= 1'b1;
        @(negedge hclk);
        check("analog_cfg", {8'h00, analog_cfg}, {8'h00, CH_INPUT_ONE, 3'h7});
        check("pin_disable", pin_digital_disable, 16'h0002);
        check("irq_wake", {14'h0, conv_irq, wake_req}, 16'h0003);
        @(posedge hclk);
        wait_mode <= 1'b0;
        rd_chk("sc1_done", ADDR_SC1, 8'hC1);
        rd_chk("res_high", ADDR_RESH, 8'h02);
        rd_chk("res_low", ADDR_RESL, 8'hA5);
        // Compare against 0x100 at both limits and both directions
        wr(ADDR_CVH, 8'h01);
        wr(ADDR_CVL, 8'h00);
        exp_res = 10'h2A5;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_SC2, {2'h0, 1'b1, cmp_gt[i], 4'h0});
            wr(ADDR_SC1, 8'h01);
            finish_conv(cmp_dat[i]);
            if (cmp_hit[i]) begin
                exp_res = cmp_dat[i] + ~10'h100 + 10'h001;
            end
            rd_chk("cmp_flag", ADDR_SC1, {cmp_hit[i], 7'h01});
            rd_chk("cmp_high", ADDR_RESH, {6'h00, exp_res[9:8]});
            rd_chk("cmp_low", ADDR_RESL, exp_res[7:0]);
        end
        // Half-read pair blocks the transfer, converter restarts regardless
        wr(ADDR_SC2, 8'h00);
        rd_chk("blk_high", ADDR_RESH, {6'h00, exp_res[9:8]});
        wr(ADDR_SC1, 8'h01);
        finish_conv(10'h155);
        rd_chk("blk_flag", ADDR_SC1, 8'h01);
        rd_chk("blk_active", ADDR_SC2, 8'h80);
        rd_chk("blk_low", ADDR_RESL, exp_res[7:0]);
        finish_conv(10'h155);
        rd_chk("blk_done", ADDR_SC1, 8'h81);
        rd_chk("new_high", ADDR_RESH, 8'h01);
        rd_chk("new_low", ADDR_RESL, 8'h55);
        // Mode write and stop3 on bus clock both drop the running conversion
        wr(ADDR_SC1, 8'h01);
        wr(ADDR_CFG, 8'h98);
        finish_conv(10'h3AA);
        rd_chk("abort_flag", ADDR_SC1, 8'h01);
        wr(ADDR_SC1, 8'h01);
        stop3_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        finish_conv(10'h111);
        stop3_mode <= 1'b0;
        rd_chk("stop3_flag", ADDR_SC1, 8'h01);
        rd_chk("stop3_keep", ADDR_RESL, 8'h55);
        // Async clock keeps converting in stop3 and wakes the system
        wr(ADDR_CFG, 8'h9B);
        wr(ADDR_SC1, 8'h41);
        stop3_mode <= 1'b1; // (low byte read above left no blocking)
        finish_conv(10'h0AB);
        @(negedge hclk);
        check("stop3_wake", {14'h0, conv_irq, wake_req}, 16'h0003);
        @(posedge hclk);
        stop3_mode <= 1'b0;
        rd_chk("async_low", ADDR_RESL, 8'hAB);
        // Hardware trigger starts a conversion while in wait
        wr(ADDR_SC2, 8'h40);
        wr(ADDR_SC1, 8'h01);
        n = start_count;
        wait_mode <= 1'b1;
        hw_trigger_input <= 1'b1;
        repeat (8) @(posedge hclk);
        check("hw_start", 16'(start_count), 16'(n + 1));
        finish_conv(10'h033);
        hw_trigger_input <= 1'b0;
        wait_mode <= 1'b0;
        rd_chk("hw_done", ADDR_SC1, 8'h81);
        // Continuous mode restarts by itself in wait; stop1/2 then drops it
        wr(ADDR_SC2, 8'h00);
        wr(ADDR_SC1, 8'h21);
        wait_mode <= 1'b1;
        finish_conv(10'h044);
        rd_chk("cont_flag", ADDR_SC1, 8'hA1);
        rd_chk("cont_active", ADDR_SC2, 8'h80);
        rd_chk("cont_low", ADDR_RESL, 8'h44);
        wait_mode <= 1'b0;
        stop12_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        stop12_mode <= 1'b0;
        @(posedge hclk);
        reset_vals();
        wrap_up();
    end
    // Run needs a few hundred cycles; a hang ends here
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        wrap_up();
    end
endmodule
bind adcc_top adcc_props_chk chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .haddr(haddr), .hwdata(hwdata), .htrans(htrans), .wait_mode(wait_mode),
    .stop3_mode(stop3_mode), .stop12_mode(stop12_mode), .conv_done(conv_done), .conv_start(conv_start),
    .conv_abort(conv_abort), .adck_tick(adck_tick), .async_clk_enable(async_clk_enable), .conv_irq(conv_irq),
    .wake_req(wake_req), .analog_cfg(analog_cfg), .pin_digital_disable(pin_digital_disable)
);
